// >>> tws_pkg.sv
// Constants and types for the two-wire slave port.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
package tws_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_OWN = 8'h20;
    localparam logic [7:0] IDX_CTRL = 8'h21;
    localparam logic [7:0] IDX_STAT = 8'h22;
    localparam logic [7:0] IDX_DATA = 8'h23;
    localparam logic [7:0] ADDR_OWN = 8'(IDX_OWN * 4);
    localparam logic [7:0] ADDR_CTRL = 8'(IDX_CTRL * 4);
    localparam logic [7:0] ADDR_STAT = 8'(IDX_STAT * 4);
    localparam logic [7:0] ADDR_DATA = 8'(IDX_DATA * 4);

    // Register select codes
    localparam logic [1:0] SEL_OWN = 2'h0;
    localparam logic [1:0] SEL_CTRL = 2'h1;
    localparam logic [1:0] SEL_STAT = 2'h2;
    localparam logic [1:0] SEL_DATA = 2'h3;

    // bus_control fields
    localparam int CTRL_ACK_BIT = 3;
    localparam int CTRL_DIR_BIT = 4;
    localparam int CTRL_EN_BIT = 7;
    localparam logic [7:0] CTRL_MASK = 8'h98;

    // bus_status fields
    localparam int STAT_ACK_RCVD_BIT = 0;
    localparam int STAT_RW_BIT = 2;
    localparam int STAT_BUSY_BIT = 5;
    localparam int STAT_MATCH_BIT = 6;
    localparam int STAT_DONE_BIT = 7;

    // Values after reset
    localparam logic [7:0] RST_OWN = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic RST_ACK_RCVD = 1'b1;

    // Bits per byte on the wire
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_HOLD = 3'b011,
        ST_TX_BITS = 3'b100,
        ST_TX_ACK = 3'b101,
        ST_RX_BITS = 3'b110,
        ST_RX_ACK = 3'b111
    } tws_state_t;

endpackage

// >>> tws_slave.sv
// Two-wire serial slave port with four byte registers on AXI4-Lite.
// Assumes external pull-ups on both lines and an outside bus master.
//
// Function
// - Lines driven low or released only
// - Slave only, transmit or receive mode
// - Own address from bits 7..1
// - After start, compare first seven bits
// - Eighth address bit stored as direction
// - Direction 0 receive, 1 transmit
// - Match sets matched flag and interrupt
// - Control write or mismatch clears matched
// - Complete flag low shifting, set after byte
// - Busy set on start, cleared on stop
// - Ack clears ack flag; nack ends sending
// - Ninth clock drives ack-to-send bit
// - Control bit 4 selects direction
// - Control bit 7 enables the port
// - Matched address acknowledged low at ninth clock
// - Clock held low until data access
// - Bytes shifted most significant first
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
module tws_slave
    import tws_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial lines, open drain
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    // Interrupt request to the CPU
    output logic bus_irq_request
);

    function automatic logic [2:0] reg_dec(input logic [ADDR_W-1:0] a);
        reg_dec = 3'h0;
        if (a == ADDR_W'(ADDR_OWN)) reg_dec = {1'b1, SEL_OWN};
        if (a == ADDR_W'(ADDR_CTRL)) reg_dec = {1'b1, SEL_CTRL};
        if (a == ADDR_W'(ADDR_STAT)) reg_dec = {1'b1, SEL_STAT};
        if (a == ADDR_W'(ADDR_DATA)) reg_dec = {1'b1, SEL_DATA};
    endfunction

    // Line synchronisers
    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    always_comb begin
        scl_rise = scl_s_q & ~scl_p_q;
        scl_fall = ~scl_s_q & scl_p_q;
        start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
        stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    end

    // Register bus state
    logic awready_q, awready_d, wready_q, wready_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] own_q, own_d, ctrl_q, ctrl_d;
    logic wr_fire, rd_fire;
    logic [2:0] wr_dec, rd_dec;

    // Serial engine state
    tws_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d, data_q, data_d;
    logic sda_oe_q, sda_oe_d, scl_oe_q, scl_oe_d;
    logic done_q, done_d, matched_q, matched_d, rw_q, rw_d;
    logic ack_rcvd_q, ack_rcvd_d, busy_q, busy_d, irq_q, irq_d;
    logic [7:0] status;

    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        own_d = own_q;
        ctrl_d = ctrl_q;
        status = 8'h00;
        status[STAT_ACK_RCVD_BIT] = ack_rcvd_q;
        status[STAT_RW_BIT] = rw_q;
        status[STAT_BUSY_BIT] = busy_q;
        status[STAT_MATCH_BIT] = matched_q;
        status[STAT_DONE_BIT] = done_q;
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        // Write acts once both halves are held
        wr_fire = aw_have_q && w_have_q && !bvalid_q;
        wr_dec = reg_dec(awaddr_q);
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_dec[2] ? RESP_OKAY : RESP_SLVERR;
            if (wr_dec[2] && wstrb_q[0]) begin
                if (wr_dec[1:0] == SEL_OWN) own_d = wdata_q[7:0];
                if (wr_dec[1:0] == SEL_CTRL) ctrl_d = wdata_q[7:0] & CTRL_MASK;
            end
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        rd_fire = s_axi_arvalid && arready_q;
        rd_dec = reg_dec(s_axi_araddr);
        if (rd_fire) begin
            rvalid_d = 1'b1;
            rresp_d = rd_dec[2] ? RESP_OKAY : RESP_SLVERR;
            rdata_d = 32'h0;
            if (rd_dec[2]) begin
                case (rd_dec[1:0])
                    SEL_OWN: rdata_d[7:0] = own_q;
                    SEL_CTRL: rdata_d[7:0] = ctrl_q;
                    SEL_STAT: rdata_d[7:0] = status;
                    default: rdata_d[7:0] = data_q;
                endcase
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0;
            own_q <= RST_OWN;
            ctrl_q <= RST_CTRL;
        end else begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            own_q <= own_d;
            ctrl_q <= ctrl_d;
        end
    end

    // Serial engine
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        data_d = data_q;
        sda_oe_d = sda_oe_q;
        done_d = done_q;
        matched_d = matched_q;
        rw_d = rw_q;
        ack_rcvd_d = ack_rcvd_q;
        busy_d = busy_q;
        irq_d = 1'b0;
        if (wr_fire && wr_dec == {1'b1, SEL_DATA} && wstrb_q[0]) begin
            data_d = wdata_q[7:0];
        end
        if (wr_fire && wr_dec == {1'b1, SEL_CTRL}) matched_d = 1'b0;
        if (start_det) busy_d = 1'b1;
        else if (stop_det) busy_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
            end
            ST_ADDR: begin
                if (scl_rise) begin
                    shift_d = {shift_q[6:0], sda_s_q};
                    cnt_d = cnt_q + 4'h1;
                end else if (scl_fall && cnt_q == BYTE_BITS) begin
                    if (shift_q[7:1] == own_q[7:1]) begin
                        matched_d = 1'b1;
                        rw_d = shift_q[0];
                        irq_d = 1'b1;
                        sda_oe_d = 1'b1;
                        state_d = ST_ADDR_ACK;
                    end else begin
                        matched_d = 1'b0;
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_ADDR_ACK: begin
                if (scl_fall) begin
                    sda_oe_d = 1'b0;
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (ctrl_q[CTRL_DIR_BIT] && wr_fire &&
                    wr_dec == {1'b1, SEL_DATA}) begin
                    shift_d = wdata_q[7:0];
                    sda_oe_d = ~wdata_q[7];
                    cnt_d = 4'h1;
                    done_d = 1'b0;
                    state_d = ST_TX_BITS;
                end else if (!ctrl_q[CTRL_DIR_BIT] && rd_fire &&
                    rd_dec == {1'b1, SEL_DATA}) begin
                    cnt_d = 4'h0;
                    done_d = 1'b0;
                    state_d = ST_RX_BITS;
                end
            end
            ST_TX_BITS: begin
                // next bit after each falling clock
                if (scl_fall) begin
                    if (cnt_q == BYTE_BITS) begin
                        sda_oe_d = 1'b0;
                        state_d = ST_TX_ACK;
                    end else begin
                        shift_d = {shift_q[6:0], 1'b0};
                        sda_oe_d = ~shift_q[6];
                        cnt_d = cnt_q + 4'h1;
                    end
                end
            end
            ST_TX_ACK: begin
                if (scl_rise) begin
                    ack_rcvd_d = sda_s_q;
                end else if (scl_fall) begin
                    done_d = 1'b1;
                    irq_d = 1'b1;
                    state_d = ack_rcvd_q ? ST_IDLE : ST_HOLD;
                end
            end
            ST_RX_BITS: begin
                if (scl_rise) begin
                    shift_d = {shift_q[6:0], sda_s_q};
                    cnt_d = cnt_q + 4'h1;
                end else if (scl_fall && cnt_q == BYTE_BITS) begin
                    data_d = shift_q;
                    sda_oe_d = ~ctrl_q[CTRL_ACK_BIT];
                    state_d = ST_RX_ACK;
                end
            end
            ST_RX_ACK: begin
                if (scl_fall) begin
                    sda_oe_d = 1'b0;
                    done_d = 1'b1;
                    irq_d = 1'b1;
                    state_d = ctrl_q[CTRL_ACK_BIT] ? ST_IDLE : ST_HOLD;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (start_det) begin
            state_d = ST_ADDR;
            cnt_d = 4'h0;
            sda_oe_d = 1'b0;
        end else if (stop_det) begin
            state_d = ST_IDLE;
            sda_oe_d = 1'b0;
        end
        if (!ctrl_q[CTRL_EN_BIT]) begin
            state_d = ST_IDLE;
            sda_oe_d = 1'b0;
        end
        scl_oe_d = (state_d == ST_HOLD);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            data_q <= RST_DATA;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            done_q <= 1'b0;
            matched_q <= 1'b0;
            rw_q <= 1'b0;
            ack_rcvd_q <= RST_ACK_RCVD;
            busy_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            data_q <= data_d;
            sda_oe_q <= sda_oe_d;
            scl_oe_q <= scl_oe_d;
            done_q <= done_d;
            matched_q <= matched_d;
            rw_q <= rw_d;
            ack_rcvd_q <= ack_rcvd_d;
            busy_q <= busy_d;
            irq_q <= irq_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign sda_o = 1'b0;
    assign scl_o = 1'b0;
    assign sda_oe = sda_oe_q;
    assign scl_oe = scl_oe_q;
    assign bus_irq_request = irq_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_disabled_quiet;
        !ctrl_q[CTRL_EN_BIT] |=> !sda_oe_q && !scl_oe_q;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("lines driven while port disabled");

    property p_busy_start;
        start_det |=> busy_q;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("busy not set after start");

    property p_busy_stop;
        stop_det && !start_det |=> !busy_q;
    endproperty
    a_busy_stop: assert property (p_busy_stop)
        else $error("busy not cleared after stop");

    property p_match_flags;
        ctrl_q[CTRL_EN_BIT] && !start_det && !stop_det &&
        state_q == ST_ADDR && scl_fall && cnt_q == BYTE_BITS &&
        shift_q[7:1] == own_q[7:1]
        |=> matched_q && bus_irq_request && sda_oe_q &&
        rw_q == $past(shift_q[0]);
    endproperty
    a_match_flags: assert property (p_match_flags)
        else $error("address match not reported");

    property p_ctrl_write_clears;
        wr_fire && wr_dec == {1'b1, SEL_CTRL} && !(state_q == ST_ADDR)
        |=> !matched_q;
    endproperty
    a_ctrl_write_clears: assert property (p_ctrl_write_clears)
        else $error("matched flag survived control write");

    property p_done_low_shifting;
        (state_q == ST_TX_BITS || state_q == ST_RX_BITS) |-> !done_q;
    endproperty
    a_done_low_shifting: assert property (p_done_low_shifting)
        else $error("complete flag set while shifting");

    property p_rx_ack_level;
        $rose(state_q == ST_RX_ACK) |-> sda_oe_q == !$past(ctrl_q[CTRL_ACK_BIT]);
    endproperty
    a_rx_ack_level: assert property (p_rx_ack_level)
        else $error("wrong acknowledge level on ninth clock");

    property p_addr_ack_low;
        state_q == ST_ADDR_ACK |-> sda_oe_q;
    endproperty
    a_addr_ack_low: assert property (p_addr_ack_low)
        else $error("address acknowledge not driven");

    property p_tx_msb_first;
        state_q == ST_TX_BITS |-> sda_oe_q == !shift_q[7];
    endproperty
    a_tx_msb_first: assert property (p_tx_msb_first)
        else $error("transmit bit does not follow shift MSB");

    property p_hold_release;
        state_q == ST_HOLD && ctrl_q[CTRL_EN_BIT] && ctrl_q[CTRL_DIR_BIT] &&
        wr_fire && wr_dec == {1'b1, SEL_DATA} && !start_det && !stop_det
        |=> !scl_oe_q && state_q == ST_TX_BITS ##1 !scl_oe_q;
    endproperty
    a_hold_release: assert property (p_hold_release)
        else $error("clock not released by data write");

endmodule

// >>> tws_master_model.sv
// Behavioural two-wire bus master facing the slave port.
// Assumes the bench resolves both wires with pull-ups.
module tws_master_model (
    // Resolved wire levels
    input wire logic scl,
    input wire logic sda,
    // High while pulling a wire low
    output logic scl_pull,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam real Q = 31.25;

    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    // One clock pulse, data set mid-low, sampled mid-high
    task automatic clk_bit(input logic b, output logic s);
        #(Q) sda_pull = !b;
        #(Q) scl_pull = 1'b0;
        wait (scl === 1'b1);
        #(Q) s = sda;
        #(Q) scl_pull = 1'b1;
    endtask

    // Start or repeated start
    task automatic start();
        #(Q) sda_pull = 1'b0;
        #(Q) scl_pull = 1'b0;
        wait (scl === 1'b1);
        #(2*Q) sda_pull = 1'b1;
        #(2*Q) scl_pull = 1'b1;
    endtask

    task automatic stop();
        #(Q) sda_pull = 1'b1;
        #(Q) scl_pull = 1'b0;
        wait (scl === 1'b1);
        #(2*Q) sda_pull = 1'b0;
        #(2*Q);
    endtask

    // Eight bits most significant first, then the acknowledge clock
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--)
            clk_bit(tx[i], rx[i]);
        clk_bit(ack_in, ack_out);
    endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the two-wire slave port.
// Assumes AXI4-Lite register access and a modelled master on the wires.
module testbench
    import tws_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TMO = 20000;

    logic aclk, aresetn;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    logic sda_o, sda_oe, scl_o, scl_oe, irq, scl_pull, sda_pull;
    wire scl_w, sda_w;
    int n_fail, checks, n_irq, cyc;

    // Open-drain wires with pull-ups
    assign scl_w = !(scl_pull || scl_oe === 1'b1);
    assign sda_w = !(sda_pull || sda_oe === 1'b1);

    tws_slave #(.ADDR_W(8)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe(scl_oe), .bus_irq_request(irq)
    );

    tws_master_model mst (
        .scl(scl_w), .sda(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull)
    );

    always #5 aclk = ~aclk;

    always @(posedge aclk) begin
        if (irq === 1'b1)
            n_irq <= n_irq + 1;
    end

    task automatic print_verdict();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == TMO) begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                          output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    // Upper bytes must always read zero
    task automatic rd(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(d & {24'hffffff, m}, {24'h0, e});
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic [7:0] rx;
        logic a;
        mst.xfer(b, 1'b1, rx, a);
        // Flags follow the wire two or three clocks late
        repeat (4) @(posedge aclk);
        chk1(a, exp_ack);
    endtask

    task automatic recv(input logic ack, input logic [7:0] e);
        logic [7:0] rx;
        logic a;
        mst.xfer(8'hff, ack, rx, a);
        // Flags follow the wire two or three clocks late
        repeat (4) @(posedge aclk);
        chk({24'h0, rx}, {24'h0, e});
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int i0;
        aclk = 1'b0;
        aresetn = 1'b0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'h1;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {n_fail, checks, n_irq, cyc} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;

        rd(ADDR_OWN, 8'hff, RST_OWN);
        rd(ADDR_CTRL, 8'hff, RST_CTRL);
        rd(ADDR_STAT, 8'hff, 8'h01);
        rd(ADDR_DATA, 8'hff, RST_DATA);
        wr(ADDR_STAT, 8'hff);
        rd(ADDR_STAT, 8'hff, 8'h01);
        axi_rd(8'h90, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        axi_wr(8'h90, 8'h11, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(ADDR_CTRL, 8'hff);
        rd(ADDR_CTRL, 8'hff, 8'h98);
        $display("end of test registers");

        wr(ADDR_OWN, 8'ha5);
        wr(ADDR_CTRL, 8'h00);
        i0 = n_irq;
        mst.start();
        send(8'ha4, 1'b1);
        mst.stop();
        chk(32'(n_irq - i0), 32'h0);
        wr(ADDR_CTRL, 8'h80);
        mst.start();
        send(8'ha6, 1'b1);
        rd(ADDR_STAT, 8'h40, 8'h00);
        mst.stop();
        rd(ADDR_STAT, 8'h20, 8'h00);
        $display("end of test disabled and mismatch");

        mst.start();
        rd(ADDR_STAT, 8'h20, 8'h20);
        i0 = n_irq;
        send(8'ha4, 1'b0);
        rd(ADDR_STAT, 8'hff, 8'h61);
        chk(32'(n_irq - i0), 32'h1);
        chk1(scl_oe, 1'b1);
        wr(ADDR_CTRL, 8'h80);
        rd(ADDR_STAT, 8'h40, 8'h00);
        rd(ADDR_DATA, 8'hff, RST_DATA);
        send(8'ha7, 1'b0);
        rd(ADDR_STAT, 8'h80, 8'h80);
        chk(32'(n_irq - i0), 32'h2);
        chk1(scl_oe, 1'b1);
        wr(ADDR_CTRL, 8'h88);
        rd(ADDR_DATA, 8'hff, 8'ha7);
        rd(ADDR_STAT, 8'h80, 8'h00);
        send(8'h3c, 1'b1);
        rd(ADDR_DATA, 8'hff, 8'h3c);
        mst.stop();
        rd(ADDR_STAT, 8'h20, 8'h00);
        $display("end of test receive");

        mst.start();
        i0 = n_irq;
        send(8'ha5, 1'b0);
        rd(ADDR_STAT, 8'h64, 8'h64);
        chk1(scl_oe, 1'b1);
        wr(ADDR_CTRL, 8'h90);
        wr(ADDR_DATA, 8'hc3);
        recv(1'b0, 8'hc3);
        rd(ADDR_STAT, 8'h81, 8'h80);
        wr(ADDR_DATA, 8'h5a);
        recv(1'b1, 8'h5a);
        rd(ADDR_STAT, 8'h01, 8'h01);
        chk1(sda_oe, 1'b0);
        chk1(scl_oe, 1'b0);
        mst.stop();
        chk(32'(n_irq - i0), 32'h3);
        chk1(sda_o, 1'b0);
        chk1(scl_o, 1'b0);
        $display("end of test transmit");
        print_verdict();
    end
endmodule
